// *** hw/adsr_pkg.sv ***
package adsr_pkg;
	// ----------------------------------------
	// word and frame geometry
	// ----------------------------------------
	localparam int          DATA_W        = 16;
	localparam logic [4:0]  BITS_PER_WORD = 5'h10;
	localparam logic [4:0]  CNT_SAT       = 5'h1f;
	localparam logic [15:0] WORD_RST      = 16'h0000;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          SYS_PERIOD_NS = 4;
	// conversion time is a plain model value, not a measured figure
	localparam int          CONV_TIME_NS  = 2000;
	localparam logic [9:0]  CONV_CNT      = 10'(CONV_TIME_NS / SYS_PERIOD_NS);
	localparam int          SCLK_MAX_MHZ  = 40;
	// half period rounded up so the host never exceeds the fastest link rate
	localparam logic [2:0]  SCLK_HALF     = 3'((1000 + 2 * SCLK_MAX_MHZ * SYS_PERIOD_NS - 1)
		/ (2 * SCLK_MAX_MHZ * SYS_PERIOD_NS));
	localparam int          CONVERT_START_N_LOW_NS  = 20;
	localparam logic [2:0]  CONVERT_START_N_CNT     = 3'((CONVERT_START_N_LOW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

	// ----------------------------------------
	// host sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ADSR_H_IDLE     = 3'b000,
		ADSR_H_START    = 3'b001,
		ADSR_H_WAIT_BSY = 3'b010,
		ADSR_H_WAIT_END = 3'b011,
		ADSR_H_READ     = 3'b100,
		ADSR_H_DONE     = 3'b101
	} adsr_hstate_t;
endpackage : adsr_pkg

// *** hw/adsr_if.sv ***
`timescale 1ns/1ns
interface adsr_if;
	logic convert_start_n;
	logic busy;
	logic cs_n;
	logic rd_n;
	logic sclk;
	logic chain_data_in;
	logic sdo_drv;
	logic sdo_oe;
	logic read_overrun_flag;
	logic serial_parallel_select;
	logic clock_source_select;
	wire  serial_data_out;

	// a released line shows the inverse of the reset bit the device holds on sdo_drv,
	// so a sample taken outside the frame always reads 1
	assign serial_data_out = sdo_oe ? sdo_drv : ~sdo_drv;

	modport device (
		input  convert_start_n,
		input  cs_n,
		input  rd_n,
		input  sclk,
		input  chain_data_in,
		input  serial_parallel_select,
		input  clock_source_select,
		output busy,
		output sdo_drv,
		output sdo_oe,
		output read_overrun_flag
	);

	modport host (
		output convert_start_n,
		output cs_n,
		output rd_n,
		output sclk,
		output chain_data_in,
		output serial_parallel_select,
		output clock_source_select,
		input  busy,
		input  serial_data_out,
		input  read_overrun_flag
	);
endinterface : adsr_if

// *** hw/adsr_device.sv ***
`timescale 1ns/1ns
// Operation
// [RL1] read after busy falls, select low
// [RL2] sixteen bits out, msb first
// [RL3] link clock up to 40 MHz
// [RL4] chaining only in read-after mode
// [RL5] chain input taken on opposite edge
// [RL6] upstream msb follows local lsb
// [RL7] host shares one convert start
// [RL8] read during conversion gives previous result
// [RL9] unfinished read during conversion flags error
// [RL10] chain input held fixed when reading during
// [RL11] during-conversion reads at 18 MHz or faster
// [RL12] reads may straddle next conversion start
// [RL13] host uses idle-low clock, second-edge sampling
// [RL14] serial-port host stays at 17 Mbps; adsr_host clocks the link at 31.25 MHz
// [RL15] host reads on busy fall, timer starts
// [RL16] link quiet during read-after conversions
// [RL17] serial select high picks serial port
// [RL18] clock select high takes host clock
// [RL19] link clock ignored while select high
// [RL20] outputs released when select or read high
// [RL21] new result loaded when busy falls
module adsr_device
	import adsr_pkg::*;
(
	// system clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rst_b_in,
	input  wire logic               clk_en_in,
	// conversion source
	input  wire logic [DATA_W-1:0]  analog_code_in,
	// result and state view
	output logic      [DATA_W-1:0]  result_out,
	output logic                    busy_out,
	// serial link
	adsr_if.device                  lnk
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic              cnv_s1;
		logic              cnv_s2;
		logic              cnv_prev;
		logic              busy;
		logic [9:0]        timer;
		logic [DATA_W-1:0] sample;
		logic [DATA_W-1:0] word;
		logic              sel_s1;
		logic              sel_s2;
		logic              sel_prev;
		logic              done_s1;
		logic              done_s2;
		logic              armed;
		logic              got;
		logic              during;
		logic              err;
	} adsr_sys_t;

	typedef struct packed {
		logic              mode_s1;
		logic              mode_s2;
		logic [4:0]        cnt;
		logic [DATA_W-1:0] sreg;
		logic              done;
	} adsr_link_t;

	adsr_sys_t  s;
	adsr_sys_t  next_s;
	adsr_link_t l;
	adsr_link_t next_l;
	logic       chain_q;
	logic       link_rst_b;
	logic       port_on;

	// ----------------------------------------
	// conversion and error logic, system clock
	// ----------------------------------------
	always_comb
	begin
		next_s         = s;
		next_s.cnv_s1  = lnk.convert_start_n;
		next_s.cnv_s2  = s.cnv_s1;
		next_s.cnv_prev = s.cnv_s2;
		next_s.sel_s1  = ~lnk.cs_n & ~lnk.rd_n;
		next_s.sel_s2  = s.sel_s1;
		next_s.sel_prev = s.sel_s2;
		next_s.done_s1 = l.done;
		next_s.done_s2 = s.done_s1;
		next_s.err     = 1'b0;
		// a frame that opens while busy reads the previous result
		if (s.sel_s2 && !s.sel_prev)
		begin
			next_s.during = s.busy;                              // [RL8]
			next_s.armed  = s.busy;
		end
		if (s.armed && s.done_s2)
		begin
			next_s.got = 1'b1;
		end
		if (s.busy)
		begin
			// a running conversion cannot be restarted
			next_s.timer = s.timer - 10'h001;
			if (s.timer == 10'h001)
			begin
				next_s.busy  = 1'b0;
				next_s.word  = s.sample;                         // [RL21]
				next_s.armed = 1'b0;
				next_s.err   = s.armed & ~(s.got | s.done_s2);   // [RL9]
			end
		end
		else if (s.cnv_prev && !s.cnv_s2)
		begin
			next_s.busy   = 1'b1;
			next_s.timer  = CONV_CNT;
			next_s.sample = analog_code_in;
			next_s.got    = 1'b0;
		end
		if (!clk_en_in)
		begin
			next_s = s;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s      <= '0;
			s.word <= WORD_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// link side, clocked by the host clock
	// ----------------------------------------
	// the host clock only counts while the port is selected; the frame
	// itself clears the link logic, so no edge is needed after a frame
	assign port_on    = lnk.serial_parallel_select & lnk.clock_source_select;  // [RL17]
	assign link_rst_b = rst_b_in & ~lnk.cs_n & ~lnk.rd_n & port_on;        // [RL19]

	// chain bit taken on the falling edge, shifted in on the rising
	always_ff @(negedge lnk.sclk or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			chain_q <= 1'b0;
		end
		else
		begin
			chain_q <= lnk.chain_data_in;                        // [RL5]
		end
	end

	always_comb
	begin
		next_l         = l;
		next_l.mode_s1 = s.during;
		next_l.mode_s2 = l.mode_s1;
		// the result word only changes at busy fall; it is copied once, at the first
		// rising link edge, so a busy fall later in the frame does not reach the link
		if (l.cnt == 5'h00)
		begin
			next_l.sreg = s.word;                                // [RL2]
			next_l.cnt  = 5'h01;
		end
		else
		begin
			// chaining only when the frame did not open during a conversion
			next_l.sreg = {l.sreg[DATA_W-2:0], chain_q & ~l.mode_s2};  // [RL4] [RL6]
			if (l.cnt != CNT_SAT)
			begin
				next_l.cnt = l.cnt + 5'h01;
			end
		end
		next_l.done = l.done | (next_l.cnt == BITS_PER_WORD);   // [RL9]
	end

	always_ff @(posedge lnk.sclk or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			l      <= '0;
			l.sreg <= WORD_RST;
		end
		else
		begin
			l <= next_l;                                        // [RL3] [RL12]
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign lnk.sdo_drv           = l.sreg[DATA_W-1];             // [RL2]
	assign lnk.sdo_oe            = ~lnk.cs_n & ~lnk.rd_n & port_on;  // [RL20] [RL18]
	assign lnk.busy              = s.busy;                       // [RL1]
	assign lnk.read_overrun_flag = s.err;
	assign result_out            = s.word;
	assign busy_out              = s.busy;
endmodule : adsr_device

// *** hw/adsr_host.sv ***
`timescale 1ns/1ns
module adsr_host
	import adsr_pkg::*;
(
	// system clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rst_b_in,
	input  wire logic               clk_en_in,
	// request
	input  wire logic               start_in,
	input  wire logic               read_during_in,
	output logic                    ready_out,
	// answer
	output logic      [DATA_W-1:0]  data_out,
	output logic                    data_valid_out,
	output logic                    overrun_out,
	output logic                    busy_out,
	// serial link
	adsr_if.host                    lnk
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		adsr_hstate_t      st;
		logic [2:0]        div;
		logic [2:0]        timer;
		logic              sclk;
		logic              cs_n;
		logic              cnv_n;
		logic [4:0]        bits;
		logic [DATA_W-1:0] shreg;
		logic [DATA_W-1:0] data;
		logic              valid;
		logic              during;
		logic              busy_s1;
		logic              busy_s2;
		logic              sdo_s1;
		logic              sdo_s2;
		logic              err_s1;
		logic              err_s2;
		logic              err_prev;
		logic              ovr;
	} adsr_host_t;

	adsr_host_t h;
	adsr_host_t next_h;

	always_comb
	begin
		next_h          = h;
		next_h.busy_s1  = lnk.busy;
		next_h.busy_s2  = h.busy_s1;
		next_h.sdo_s1   = lnk.serial_data_out;
		next_h.sdo_s2   = h.sdo_s1;
		next_h.err_s1   = lnk.read_overrun_flag;
		next_h.err_s2   = h.err_s1;
		next_h.err_prev = h.err_s2;
		next_h.ovr      = h.err_s2 & ~h.err_prev;
		next_h.valid    = 1'b0;
		case (h.st)
			ADSR_H_IDLE:
			begin
				if (start_in && !h.busy_s2)
				begin
					next_h.cnv_n  = 1'b0;                       // [RL7]
					next_h.timer  = CONVERT_START_N_CNT;
					next_h.during = read_during_in;
					next_h.st     = ADSR_H_START;
				end
			end
			ADSR_H_START:
			begin
				next_h.timer = h.timer - 3'h1;
				if (h.timer == 3'h1)
				begin
					next_h.cnv_n = 1'b1;
					next_h.st    = ADSR_H_WAIT_BSY;
				end
			end
			ADSR_H_WAIT_BSY:
			begin
				if (h.busy_s2)
				begin
					next_h.st = h.during ? ADSR_H_READ : ADSR_H_WAIT_END;
					next_h.cs_n = ~h.during;                    // [RL8]
					next_h.div  = SCLK_HALF;
					next_h.bits = 5'h00;
				end
			end
			ADSR_H_WAIT_END:
			begin
				// clock stays idle until the conversion is over
				if (!h.busy_s2)
				begin
					next_h.cs_n = 1'b0;                         // [RL1] [RL15] [RL16]
					next_h.st   = ADSR_H_READ;
				end
			end
			ADSR_H_READ:
			begin
				next_h.div = h.div - 3'h1;
				if (h.div == 3'h1)
				begin
					next_h.div  = SCLK_HALF;                    // [RL3] [RL11]
					next_h.sclk = ~h.sclk;
					// idle-low clock, data taken on the falling edge
					if (h.sclk)
					begin
						next_h.shreg = {h.shreg[DATA_W-2:0], h.sdo_s2};  // [RL13]
						next_h.bits  = h.bits + 5'h01;
						if (h.bits == BITS_PER_WORD - 5'h01)
						begin
							next_h.st = ADSR_H_DONE;
						end
					end
				end
			end
			ADSR_H_DONE:
			begin
				next_h.cs_n  = 1'b1;
				next_h.data  = h.shreg;
				next_h.valid = 1'b1;
				next_h.st    = ADSR_H_IDLE;
			end
			default:
			begin
				next_h.st = ADSR_H_IDLE;
			end
		endcase
		if (!clk_en_in)
		begin
			next_h = h;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			h       <= '0;
			h.st    <= ADSR_H_IDLE;
			h.cs_n  <= 1'b1;
			h.cnv_n <= 1'b1;
		end
		else
		begin
			h <= next_h;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign lnk.convert_start_n        = h.cnv_n;
	assign lnk.cs_n                   = h.cs_n;
	assign lnk.rd_n                   = h.cs_n;
	assign lnk.sclk                   = h.sclk;
	assign lnk.chain_data_in          = 1'b0;                    // [RL10]
	assign lnk.serial_parallel_select = 1'b1;                    // [RL17]
	assign lnk.clock_source_select    = 1'b1;
	assign ready_out                  = (h.st == ADSR_H_IDLE) & ~h.busy_s2;
	assign data_out                   = h.data;
	assign data_valid_out             = h.valid;
	assign overrun_out                = h.ovr;
	assign busy_out                   = h.busy_s2;
endmodule : adsr_host

// *** verif/adsr_asserts.sv ***
`timescale 1ns/1ns
module adsr_asserts
	import adsr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// link lines
	input wire logic convert_start_n,
	input wire logic busy,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic sclk,
	input wire logic chain_data_in,
	input wire logic sdo_drv,
	input wire logic sdo_oe,
	input wire logic read_overrun_flag,
	input wire logic serial_parallel_select,
	input wire logic clock_source_select
);
	logic       sclk_q;
	logic [4:0] rises;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	// ----
	// rising link edges in the open frame
	// ----
	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sclk_q <= 1'b0;
			rises  <= 5'h00;
		end
		else
		begin
			sclk_q <= sclk;
			if (cs_n)
				rises <= 5'h00;
			else if (sclk && !sclk_q)
				rises <= rises + 5'h01;
		end
	end

	oe_gate_a:
		assert property (sdo_oe == (!cs_n && !rd_n && serial_parallel_select
			&& clock_source_select)) else $error("enable off select");
	bit_count_a:
		assert property ($rose(cs_n) |-> rises == BITS_PER_WORD) else $error("bit count");
	sdo_edge_a:
		assert property (sdo_oe && $past(sdo_oe) && (sdo_drv != $past(sdo_drv))
			|-> $rose(sclk)) else $error("data moved off rising edge");
	sdo_hold_a:
		assert property ($fell(sclk) && sdo_oe |-> $stable(sdo_drv)) else $error("data moved");
	clk_high_a:
		assert property ($rose(sclk) |-> sclk[*4]) else $error("link clock high too short");
	clk_low_a:
		assert property ($fell(sclk) |-> (!sclk)[*4]) else $error("link clock low too short");
	clk_idle_a:
		assert property (cs_n |-> !sclk) else $error("link clock outside frame");
	chain_fixed_a:
		assert property (!cs_n && busy |-> $stable(chain_data_in)) else $error("chain moved");
	sel_tied_a:
		assert property (serial_parallel_select && clock_source_select) else $error("select");
	err_pulse_a:
		assert property (read_overrun_flag |=> !read_overrun_flag) else $error("error width");
	err_end_a:
		assert property ($rose(read_overrun_flag) |-> !busy && ($past(busy) || $past(busy, 2)))
		else $error("error not at conversion end");
	conv_hold_a:
		assert property ($rose(busy) |-> busy[*8]) else $error("conversion cut short");
	conv_start_a:
		assert property ($fell(convert_start_n) && !busy |-> ##[1:8] busy)
		else $error("conversion not started");
endmodule : adsr_asserts

// *** verif/adc_slave_serial_readout_test.sv ***
`timescale 1ns/1ns
module adc_slave_serial_readout_test;
	import adsr_pkg::*;
	logic              sys_clk_in;
	logic              rst_b_in;
	logic              host_en;
	logic              start_in;
	logic              read_during_in;
	logic [DATA_W-1:0] analog_code_in;
	logic [DATA_W-1:0] result_out;
	logic              dev_busy;
	logic              ready_out;
	logic [DATA_W-1:0] data_out;
	logic              data_valid_out;
	logic              host_ovr;
	logic              host_busy;
	logic [DATA_W-1:0] prev;
	logic [DATA_W-1:0] codes [6] = '{16'ha5c3, 16'h3c5a, 16'h8001, 16'hffff, 16'h0000, 16'h7ffe};
	int                errors = 0;
	int                n_compared = 0;
	int                n_flag = 0;
	int                n_ovr = 0;

	adsr_if adsr_if_i ();
	adsr_device adsr_device_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
		.analog_code_in(analog_code_in), .result_out(result_out), .busy_out(dev_busy),
		.lnk(adsr_if_i.device));
	adsr_host adsr_host_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(host_en),
		.start_in(start_in), .read_during_in(read_during_in), .ready_out(ready_out),
		.data_out(data_out), .data_valid_out(data_valid_out), .overrun_out(host_ovr),
		.busy_out(host_busy),
		.lnk(adsr_if_i.host));
	adsr_asserts adsr_asserts_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.convert_start_n(adsr_if_i.convert_start_n), .busy(adsr_if_i.busy),
		.cs_n(adsr_if_i.cs_n), .rd_n(adsr_if_i.rd_n), .sclk(adsr_if_i.sclk),
		.chain_data_in(adsr_if_i.chain_data_in), .sdo_drv(adsr_if_i.sdo_drv),
		.sdo_oe(adsr_if_i.sdo_oe), .read_overrun_flag(adsr_if_i.read_overrun_flag),
		.serial_parallel_select(adsr_if_i.serial_parallel_select),
		.clock_source_select(adsr_if_i.clock_source_select));

	initial
	begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	// pulses are counted away from the edge that launches them
	always @(negedge sys_clk_in)
	begin
		if (adsr_if_i.read_overrun_flag === 1'b1)
			n_flag++;
		if (host_ovr === 1'b1)
			n_ovr++;
	end

	// ----
	// shared tasks
	// ----
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(inout int n);
		@(negedge sys_clk_in);
		n++;
	endtask : tick

	// stall freezes the host mid-frame so the conversion ends under an open read
	task automatic xfer(input logic during, input logic [DATA_W-1:0] code, input logic stall);
		int n;
		int f0;
		int o0;
		n = 0;
		f0 = n_flag;
		o0 = n_ovr;
		while (ready_out !== 1'b1 && n < 9000)
			tick(n);
		analog_code_in = code;
		read_during_in = during;
		start_in = 1'b1;
		@(negedge sys_clk_in);
		start_in = 1'b0;
		while (dev_busy !== 1'b1 && n < 9000)
			tick(n);
		check(16'(ready_out), 16'h0000);
		repeat (2) tick(n);
		check(16'(host_busy), 16'h0001);
		if (stall)
		begin
			while (adsr_if_i.cs_n !== 1'b0 && n < 9000)
				tick(n);
			repeat (40) @(negedge sys_clk_in);
			host_en = 1'b0;
			while (dev_busy !== 1'b0 && n < 9000)
				tick(n);
			// resume at once so the host still catches the error pulse
			host_en = 1'b1;
		end
		while (data_valid_out !== 1'b1 && n < 9000)
			tick(n);
		check(data_out, during ? prev : code);
		while (dev_busy !== 1'b0 && n < 9000)
			tick(n);
		check(result_out, code);
		check(16'(n_flag - f0), 16'(stall));
		check(16'(n_ovr - o0), 16'(stall));
		check(16'(n < 9000), 16'h0001);
		prev = code;
	endtask : xfer

	task automatic wrap_up();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	// ----
	// scenarios
	// ----
	initial
	begin
		prev = WORD_RST;
		rst_b_in = 1'b0;
		host_en = 1'b1;
		start_in = 1'b0;
		read_during_in = 1'b0;
		analog_code_in = 16'h0000;
		repeat (5) @(negedge sys_clk_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		foreach (codes[k])
			xfer(k[0], codes[k], 1'b0);
		xfer(1'b1, 16'h1234, 1'b1);
		xfer(1'b0, 16'hc0de, 1'b0);
		xfer(1'b1, 16'h5555, 1'b0);
		wrap_up();
	end

	// whole run needs well under 40k cycles
	initial
	begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule : adc_slave_serial_readout_test
